/* File: rtl/pbcs_pkg.sv */
// package: register map, field layout and constants of the clock selector
package pbcs_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] PBCS_OFF_CONTROL   = 8'h00;
    localparam logic [7:0] PBCS_OFF_BANDWIDTH = 8'h04;
    localparam logic [7:0] PBCS_OFF_MULT_CFG  = 8'h08;
    localparam logic [7:0] PBCS_OFF_IRQ_STAT  = 8'h0c;
    localparam logic [7:0] PBCS_OFF_IRQ_MASK  = 8'h10;

    // pll_control_reg fields
    localparam int PBCS_CTL_IRQ_EN   = 7;
    localparam int PBCS_CTL_FLAG     = 6;
    localparam int PBCS_CTL_PWR_ON   = 5;
    localparam int PBCS_CTL_BCS      = 4;
    localparam logic [3:0] PBCS_CTL_UNUSED = 4'hf;

    // bandwidth register fields
    localparam int PBCS_BW_AUTO = 7;
    localparam int PBCS_BW_LOCK = 6;

    // pll_multiplier_config fields and reset value
    localparam int PBCS_MUL_LSB = 4;
    localparam int PBCS_VRS_LSB = 0;
    localparam logic [7:0] PBCS_MULT_CFG_RST = 8'h66;

    // irq status and mask bit positions
    localparam int PBCS_IRQ_LOCK   = 0;
    localparam int PBCS_IRQ_SWITCH = 1;
    localparam int PBCS_IRQ_BITS   = 2;

    // reset values of the control bits
    localparam logic PBCS_PWR_ON_RST = 1'b1;
    localparam logic PBCS_AUTO_RST   = 1'b0;

    // source cycles waited on each side during a changeover
    localparam logic [1:0] PBCS_SWITCH_CYCLES = 2'h3;

endpackage

/* File: rtl/pbcs_clock_switch.sv */
// glitch-free source changeover and divide-by-two for the base clock
`timescale 1ns/1ps
module pbcs_clock_switch
    import pbcs_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic xclk_s,
    input  wire logic vclk_s,
    input  wire logic sel_vco,
    output logic      base_clock,
    output logic      cur_vco,
    output logic      switch_done
);

    typedef enum logic {PBCS_SW_RUN, PBCS_SW_WAIT} pbcs_sw_state_t;

    pbcs_sw_state_t state;
    logic           xclk_prev;
    logic           vclk_prev;
    logic [1:0]     xcnt;
    logic [1:0]     vcnt;

    wire logic x_rise   = xclk_s & ~xclk_prev;
    wire logic v_rise   = vclk_s & ~vclk_prev;
    wire logic src_rise = cur_vco ? v_rise : x_rise;
    wire logic x_full   = (xcnt == PBCS_SWITCH_CYCLES);
    wire logic v_full   = (vcnt == PBCS_SWITCH_CYCLES);
    wire logic finish   = (state == PBCS_SW_WAIT) & x_full & v_full;

    // edge history of the already synchronised source clocks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            xclk_prev <= 1'b0;
            vclk_prev <= 1'b0;
        end
        else
        begin
            xclk_prev <= xclk_s;
            vclk_prev <= vclk_s;
        end
    end

    // changeover: wait three cycles of each source, output frozen
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state       <= PBCS_SW_RUN;
            cur_vco     <= 1'b0;
            xcnt        <= 2'h0;
            vcnt        <= 2'h0;
            switch_done <= 1'b0;
        end
        else
        begin
            switch_done <= finish;
            unique case (state)
                PBCS_SW_RUN:
                begin
                    xcnt <= 2'h0;
                    vcnt <= 2'h0;
                    if (sel_vco != cur_vco)
                        state <= PBCS_SW_WAIT;
                end
                PBCS_SW_WAIT:
                begin
                    if (x_rise && !x_full)
                        xcnt <= xcnt + 2'h1;
                    if (v_rise && !v_full)
                        vcnt <= vcnt + 2'h1;
                    if (finish)
                    begin
                        cur_vco <= sel_vco;
                        state   <= PBCS_SW_RUN;
                    end
                end
            endcase
        end
    end

    // toggling once per source rising edge halves it to an even duty
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            base_clock <= 1'b0;
        else if (state == PBCS_SW_RUN && src_rise)
            base_clock <= ~base_clock;
    end

endmodule

/* File: rtl/pbcs_top.sv */
// pll programming, base clock selection and lock interrupt with apb access
//
// Contract
// - N comes from the upper four bits of the multiplier config register.
// - L comes from the lower four bits of the multiplier config register.
// - N programmed as zero divides exactly like N equal to one.
// - L equal to zero disables the pll and bars vco selection.
// - With L zero the crystal clock is forced as base clock source.
// - Changeover waits three crystal and three vco cycles, output held.
// - Selected source is divided by two for an even duty cycle.
// - Base clock is twice bus rate, bus is a quarter of source.
// - Base clock select bit: clear picks crystal, set picks vco.
// - Vco cannot be selected while pll power is off.
// - Pll power cannot be cleared while vco is the selected source.
// - One write never both changes pll power and the vco selection.
// - Base clock output goes to the system integration unit.
// - Processor interrupt output is produced from the lock detector.
// - Lock toggle sets flag; enabled flag interrupts; control read clears.
// - Multiplier and range fields are write-blocked while pll is on.
// - Reset loads six into the multiplier field.
`timescale 1ns/1ps
module pbcs_top
    import pbcs_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        crystal_clock,
    input  wire logic        vco_clock,
    input  wire logic        pll_lock_in,
    input  wire logic        osc_enable_in,
    output logic             base_clock_out,
    output logic             pll_enable_out,
    output logic      [3:0]  feedback_div_n,
    output logic      [3:0]  vco_range_l,
    output logic             clockgen_irq
);

    // two-stage synchronisers for every asynchronous input
    logic xclk_m;
    logic xclk_s;
    logic vclk_m;
    logic vclk_s;
    logic lock_m;
    logic lock_s;
    logic osc_m;
    logic osc_s;

    // software-visible state and lock edge history
    logic       pll_irq_enable;
    logic       pll_lock_change_flag;
    logic       pll_power_on;
    logic       base_clock_select;
    logic       auto_mode;
    logic [3:0] feedback_multiplier_field;
    logic [3:0] vco_range_field;
    logic [PBCS_IRQ_BITS-1:0] irq_status;
    logic [PBCS_IRQ_BITS-1:0] irq_mask;
    logic       lock_prev;

    // switch results
    logic sw_base_clock;
    logic sw_cur_vco;
    logic sw_done;

    // zero multiplier behaves like one
    function automatic logic [3:0] pbcs_eff_n(input logic [3:0] mul);
        pbcs_eff_n = (mul == 4'h0) ? 4'h1 : mul;
    endfunction

    // synchronisers: the first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            xclk_m <= 1'b0;
            xclk_s <= 1'b0;
            vclk_m <= 1'b0;
            vclk_s <= 1'b0;
            lock_m <= 1'b0;
            lock_s <= 1'b0;
            osc_m  <= 1'b0;
            osc_s  <= 1'b0;
        end
        else
        begin
            xclk_m <= crystal_clock;
            xclk_s <= xclk_m;
            vclk_m <= vco_clock;
            vclk_s <= vclk_m;
            lock_m <= pll_lock_in;
            lock_s <= lock_m;
            osc_m  <= osc_enable_in;
            osc_s  <= osc_m;
        end
    end

    // apb decode; a transfer completes when pready is seen high
    wire logic access    = psel & penable;
    wire logic done      = access & pready;
    wire logic wr        = done & pwrite;
    wire logic rd        = done & ~pwrite;

    // address hits; any other offset answers with an error
    wire logic hit_ctl   = (paddr == PBCS_OFF_CONTROL);
    wire logic hit_bw    = (paddr == PBCS_OFF_BANDWIDTH);
    wire logic hit_mult  = (paddr == PBCS_OFF_MULT_CFG);
    wire logic hit_stat  = (paddr == PBCS_OFF_IRQ_STAT);
    wire logic hit_mask  = (paddr == PBCS_OFF_IRQ_MASK);
    wire logic mapped    = hit_ctl | hit_bw | hit_mult | hit_stat | hit_mask;

    // per-register strobes, true only in the completing cycle
    wire logic wr_ctl    = wr & hit_ctl;
    wire logic wr_bw     = wr & hit_bw;
    wire logic wr_mult   = wr & hit_mult;
    wire logic wr_mask   = wr & hit_mask;
    wire logic rd_ctl    = rd & hit_ctl;
    wire logic rd_stat   = rd & hit_stat;

    // write data as seen by the control bits
    wire logic req_on    = pwdata[PBCS_CTL_PWR_ON];
    wire logic req_bcs   = pwdata[PBCS_CTL_BCS];
    wire logic range_off = (vco_range_field == 4'h0);

    // power may drop only with crystal selected; judged on old select
    wire logic next_pll_power_on =
        (wr_ctl && !base_clock_select) ? req_on : pll_power_on;

    // vco selectable only with pll already on and L nonzero; a write
    // that drops power must not select the vco in the same stroke
    wire logic keeps_power = req_on | base_clock_select;
    wire logic bcs_allowed =
        pll_power_on & keeps_power & ~range_off;
    wire logic next_base_clock_select =
        range_off ? 1'b0 :
        (wr_ctl ? (req_bcs & bcs_allowed) : base_clock_select);

    // lock toggles are meaningful only in automatic mode
    wire logic lock_toggle = auto_mode & (lock_s ^ lock_prev);

    // flag: a toggle in the same cycle as the clearing read wins
    wire logic next_flag =
        lock_toggle | (pll_lock_change_flag & ~rd_ctl);

    // sticky status, read-to-clear; new events win over the clear
    wire logic [PBCS_IRQ_BITS-1:0] irq_events = {sw_done, lock_toggle};
    wire logic [PBCS_IRQ_BITS-1:0] next_irq_status =
        irq_events | (irq_status & {PBCS_IRQ_BITS{~rd_stat}});

    // interrupt request: enabled lock flag or any unmasked status bit
    wire logic next_irq =
        (next_flag & pll_irq_enable & auto_mode) |
        (|(next_irq_status & irq_mask));

    // config writes land only while the pll is off
    wire logic mult_wr_ok = wr_mult & ~pll_power_on;

    // range field after a possible write, used for the enable
    wire logic [3:0] next_mult_vrs = mult_wr_ok ?
        pwdata[PBCS_VRS_LSB +: 4] : vco_range_field;

    // pll runs only when powered, L nonzero and oscillator enabled
    wire logic next_pll_enable =
        next_pll_power_on & (next_mult_vrs != 4'h0) & osc_s;

    // read views of each register
    wire logic [7:0] ctl_view = {
        pll_irq_enable & auto_mode,
        pll_lock_change_flag & auto_mode,
        pll_power_on,
        base_clock_select,
        PBCS_CTL_UNUSED};
    wire logic [7:0] bw_view   = {auto_mode, lock_s & auto_mode, 6'h00};
    wire logic [7:0] mult_view = {feedback_multiplier_field,
                                  vco_range_field};
    wire logic [7:0] stat_view = {{(8-PBCS_IRQ_BITS){1'b0}}, irq_status};
    wire logic [7:0] mask_view = {{(8-PBCS_IRQ_BITS){1'b0}}, irq_mask};
    wire logic [7:0] rd_view =
        hit_ctl  ? ctl_view  :
        hit_bw   ? bw_view   :
        hit_mult ? mult_view :
        hit_stat ? stat_view :
        hit_mask ? mask_view : 8'h00;

    // apb answer: exactly one wait state before pready
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= access & ~pready;
    end

    // read data stands with pready only, zero otherwise
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else
            prdata <= (access & ~pready & ~pwrite) ?
                      {24'h00_0000, rd_view} : 32'h0000_0000;
    end

    // unmapped offsets answer with an error pulse beside pready
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pslverr <= 1'b0;
        else
            pslverr <= access & ~pready & ~mapped;
    end

    // pll power, held on while the vco drives the base clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pll_power_on <= PBCS_PWR_ON_RST;
        else
            pll_power_on <= next_pll_power_on;
    end

    // base clock select, forced clear whenever L reads zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            base_clock_select <= 1'b0;
        else
            base_clock_select <= next_base_clock_select;
    end

    // bandwidth mode bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            auto_mode <= PBCS_AUTO_RST;
        else if (wr_bw)
            auto_mode <= pwdata[PBCS_BW_AUTO];
    end

    // irq enable is writable only in automatic mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pll_irq_enable <= 1'b0;
        else if (wr_ctl && auto_mode)
            pll_irq_enable <= pwdata[PBCS_CTL_IRQ_EN];
    end

    // multiplier config: protected while the pll is on, resets to six
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            feedback_multiplier_field <=
                PBCS_MULT_CFG_RST[PBCS_MUL_LSB +: 4];
            vco_range_field <= PBCS_MULT_CFG_RST[PBCS_VRS_LSB +: 4];
        end
        else if (mult_wr_ok)
        begin
            feedback_multiplier_field <= pwdata[PBCS_MUL_LSB +: 4];
            vco_range_field           <= pwdata[PBCS_VRS_LSB +: 4];
        end
    end

    // lock flag, interrupt status and mask
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_prev            <= 1'b0;
            pll_lock_change_flag <= 1'b0;
            irq_status           <= '0;
            irq_mask             <= '0;
        end
        else
        begin
            lock_prev            <= lock_s;
            pll_lock_change_flag <= next_flag;
            irq_status           <= next_irq_status;
            if (wr_mask)
                irq_mask <= pwdata[PBCS_IRQ_BITS-1:0];
        end
    end

    // pll enable toward the analog loop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pll_enable_out <= 1'b0;
        else
            pll_enable_out <= next_pll_enable;
    end

    // divider value, zero already mapped to one
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            feedback_div_n <= 4'h1;
        else
            feedback_div_n <= pbcs_eff_n(feedback_multiplier_field);
    end

    // range value; the loop takes L straight from the register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            vco_range_l <= 4'h0;
        else
            vco_range_l <= vco_range_field;
    end

    // level interrupt, registered so the pin never glitches
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clockgen_irq <= 1'b0;
        else
            clockgen_irq <= next_irq;
    end

    // base clock to the system integration unit, one flop late
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            base_clock_out <= 1'b0;
        else
            base_clock_out <= sw_base_clock;
    end

    // changeover and divider run off the synchronised sources
    pbcs_clock_switch u_switch (
        .pclk        (pclk),
        .presetn     (presetn),
        .xclk_s      (xclk_s),
        .vclk_s      (vclk_s),
        .sel_vco     (base_clock_select),
        .base_clock  (sw_base_clock),
        .cur_vco     (sw_cur_vco),
        .switch_done (sw_done)
    );

    // the active source is only observed through the switch event
    wire logic unused_cur_vco = sw_cur_vco;

endmodule

/* File: verif/pbcs_sys_model.sv */
// system unit model: clock sources, lock detector and oscillator enable
`timescale 1ns/1ps
module pbcs_sys_model
(
    input  wire logic pclk,
    input  wire logic osc_cmd,
    input  wire logic lock_cmd,
    input  wire logic base_clock_out,
    output logic      crystal_clock,
    output logic      vco_clock,
    output logic      pll_lock_in,
    output logic      osc_enable_in
);
    // free-running sources, both slower than pclk/2 so sampling sees them
    initial
    begin
        crystal_clock = 1'b0;
        forever #45 crystal_clock = ~crystal_clock;
    end
    initial
    begin
        vco_clock = 1'b0;
        forever #35 vco_clock = ~vco_clock;
    end
    initial
    begin
        osc_enable_in = 1'b0;
        pll_lock_in   = 1'b0;
    end
    // enable and lock level move only just after pclk edges
    always @(posedge pclk)
    begin
        osc_enable_in <= osc_cmd;
        pll_lock_in   <= lock_cmd;
    end
endmodule

/* File: verif/pbcs_top_chk.sv */
// concurrent checks on the ports of the clock selector top
`timescale 1ns/1ps
module pbcs_top_chk
    import pbcs_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        crystal_clock,
    input wire logic        vco_clock,
    input wire logic        pll_lock_in,
    input wire logic        osc_enable_in,
    input wire logic        base_clock_out,
    input wire logic        pll_enable_out,
    input wire logic [3:0]  feedback_div_n,
    input wire logic [3:0]  vco_range_l,
    input wire logic        clockgen_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // completing accesses, decoded once
    wire done   = psel && penable && pready;
    wire ctl_rd = done && !pwrite && paddr == PBCS_OFF_CONTROL;
    wire cfg_rd = done && !pwrite && paddr == PBCS_OFF_MULT_CFG;
    wire cfg_wr = done && pwrite && paddr == PBCS_OFF_MULT_CFG;

    a_n_nonzero: assert property (feedback_div_n != 4'h0)
        else $error("feedback divider shows zero");
    a_l_zero_off: assert property (
        (vco_range_l == 4'h0) [*2] |-> !pll_enable_out)
        else $error("pll enabled with range zero");
    a_base_hold: assert property (
        $changed(base_clock_out) |=> $stable(base_clock_out))
        else $error("base clock toggled on adjacent cycles");
    a_mult_locked: assert property (
        cfg_wr && pll_enable_out |=> $stable(feedback_div_n) [*2])
        else $error("multiplier changed while pll on");
    a_osc_gates: assert property (
        (!osc_enable_in) [*4] |-> !pll_enable_out)
        else $error("pll enabled without oscillator enable");
    a_cfg_readback: assert property (cfg_rd |->
        prdata[3:0] == vco_range_l && feedback_div_n ==
        ((prdata[7:4] == 4'h0) ? 4'h1 : prdata[7:4]))
        else $error("config fields disagree with outputs");
    a_sel_pwr: assert property (
        ctl_rd |-> !(prdata[PBCS_CTL_BCS] && !prdata[PBCS_CTL_PWR_ON]))
        else $error("vco selected with pll power off");
    a_sel_l: assert property (
        ctl_rd && prdata[PBCS_CTL_BCS] |-> vco_range_l != 4'h0)
        else $error("vco selected with range zero");

    c_vco_sel: cover property (ctl_rd && prdata[PBCS_CTL_BCS]);
    c_irq: cover property (clockgen_irq);
    c_slverr: cover property (pslverr);
    c_locked_wr: cover property (cfg_wr && pll_enable_out);
endmodule
bind pbcs_top pbcs_top_chk pbcs_top_chk_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .crystal_clock, .vco_clock, .pll_lock_in, .osc_enable_in,
    .base_clock_out, .pll_enable_out, .feedback_div_n, .vco_range_l,
    .clockgen_irq);

/* File: verif/test_pll_base_clock_selector.sv */
// self-checking bench for the clock selector with a register model
`timescale 1ns/1ps
module test_pll_base_clock_selector;
    import pbcs_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        crystal_clock, vco_clock, pll_lock_in, osc_enable_in;
    logic        base_clock_out, pll_enable_out, clockgen_irq;
    logic [3:0]  feedback_div_n, vco_range_l;
    logic        osc_cmd, lock_cmd;
    int          n_errors, check_count;
    int          m_pwr, m_sel, m_auto, m_ie, m_flag, m_lock, m_st, m_mask;
    logic [7:0]  m_mul;
    logic [7:0]  adr [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};

    pbcs_top pbcs_top_i (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .crystal_clock,
        .vco_clock, .pll_lock_in, .osc_enable_in, .base_clock_out,
        .pll_enable_out, .feedback_div_n, .vco_range_l, .clockgen_irq);
    pbcs_sys_model pbcs_sys_model_i (.pclk, .osc_cmd, .lock_cmd,
        .base_clock_out, .crystal_clock, .vco_clock, .pll_lock_in,
        .osc_enable_in);

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [7:0] d, output logic [31:0] r,
                       output logic e);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do
        begin
            @(posedge pclk);
            t++;
        end
        while (pready !== 1'b1 && t < 50);
        if (t >= 50)
            n_errors++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // write, then update the model with the interlocks on old values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        int          s;
        apb(1'b1, a, d, r, e);
        if (a == PBCS_OFF_CONTROL)
        begin
            if (m_auto)
                m_ie = d[7];
            s = d[4] && m_pwr && (d[5] || m_sel)
                && m_mul[3:0] != 4'h0;
            if (!m_sel)
                m_pwr = d[5];
            if (s != m_sel)
                m_st |= 2;
            m_sel = s;
        end
        else if (a == PBCS_OFF_BANDWIDTH)
            m_auto = d[7];
        else if (a == PBCS_OFF_MULT_CFG && !m_pwr)
            m_mul = d;
        else if (a == PBCS_OFF_IRQ_MASK)
            m_mask = d[1:0];
        if (m_mul[3:0] == 4'h0)
            m_sel = 0;
    endtask

    task automatic rd(input logic [7:0] a);
        logic [31:0] r, x;
        logic        e;
        case (a)
            PBCS_OFF_CONTROL: x = {m_ie[0] & m_auto[0],
                m_flag[0] & m_auto[0], m_pwr[0], m_sel[0], 4'hf};
            PBCS_OFF_BANDWIDTH: x = {m_auto[0], m_lock[0] & m_auto[0], 6'h0};
            PBCS_OFF_MULT_CFG: x = m_mul;
            PBCS_OFF_IRQ_STAT: x = m_st;
            PBCS_OFF_IRQ_MASK: x = m_mask;
            default: x = 0;
        endcase
        apb(1'b0, a, 8'h00, r, e);
        chk("prdata", r, x);
        chk("pslverr", e, a > PBCS_OFF_IRQ_MASK);
        if (a == PBCS_OFF_CONTROL)
            m_flag = 0;
        if (a == PBCS_OFF_IRQ_STAT)
            m_st = 0;
    endtask

    task automatic chk_irq();
        repeat (6) @(posedge pclk);
        chk("clockgen_irq", clockgen_irq, (m_flag && m_ie && m_auto)
            || (m_st & m_mask) != 0);
    endtask

    task automatic toggle_lock();
        @(posedge pclk);
        lock_cmd <= !lock_cmd;
        m_lock = !m_lock;
        m_flag = 1;
        m_st |= 1;
        repeat (8) @(posedge pclk);
    endtask

    // sampling jitter of a pclk on each edge is allowed for
    task automatic period(input realtime exp);
        realtime t0;
        @(posedge base_clock_out);
        t0 = $realtime;
        @(posedge base_clock_out);
        chk("base period", ($realtime - t0 - exp) < 25.0
            && (exp - $realtime + t0) < 25.0, 1'b1);
    endtask

    // output must sit still while the changeover counts source edges
    task automatic switch_to(input logic [7:0] d, input realtime exp);
        logic b;
        int   t, moved;
        wr(PBCS_OFF_CONTROL, d);
        repeat (4) @(posedge pclk);
        b = base_clock_out;
        moved = 0;
        repeat (10) @(posedge pclk) if (base_clock_out !== b) moved = 1;
        chk("stasis", moved, 0);
        t = 0;
        while (clockgen_irq !== 1'b1 && t < 400)
        begin
            @(posedge pclk);
            t++;
        end
        chk("switch done", clockgen_irq, 1'b1);
        period(exp);
        rd(PBCS_OFF_IRQ_STAT);
        chk_irq();
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // watchdog, far beyond the few hundred cycles the tests take
    initial
    begin
        #200000;
        n_errors++;
        stop_test();
    end

    initial
    begin
        logic [7:0] v;
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        osc_cmd = 1;
        lock_cmd = 0;
        {n_errors, check_count, m_sel, m_auto, m_ie} = 0;
        {m_flag, m_lock, m_st, m_mask} = 0;
        m_pwr = 1;
        m_mul = PBCS_MULT_CFG_RST;
        v = 8'($urandom(18));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (adr[i]) rd(adr[i]);
        chk("n", feedback_div_n, 4'h6);
        chk("pll_en", pll_enable_out, 1'b1);
        wr(PBCS_OFF_MULT_CFG, 8'h12);
        rd(PBCS_OFF_MULT_CFG);
        wr(PBCS_OFF_CONTROL, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            v = 8'($urandom);
            if (i == 0)
                v[7:4] = 4'h0;
            wr(PBCS_OFF_MULT_CFG, v);
            repeat (2) @(posedge pclk);
            chk("n", feedback_div_n, v[7:4] == 0 ? 4'h1 : v[7:4]);
            chk("l", vco_range_l, v[3:0]);
            rd(PBCS_OFF_MULT_CFG);
        end
        wr(PBCS_OFF_MULT_CFG, 8'h35);
        wr(PBCS_OFF_CONTROL, 8'h30);
        rd(PBCS_OFF_CONTROL);
        wr(PBCS_OFF_CONTROL, 8'h10);
        rd(PBCS_OFF_CONTROL);
        wr(PBCS_OFF_CONTROL, 8'h20);
        wr(PBCS_OFF_IRQ_MASK, 8'h02);
        switch_to(8'h30, 140.0);
        wr(PBCS_OFF_CONTROL, 8'h10);
        rd(PBCS_OFF_CONTROL);
        switch_to(8'h20, 180.0);
        wr(PBCS_OFF_CONTROL, 8'h00);
        wr(PBCS_OFF_MULT_CFG, 8'h40);
        wr(PBCS_OFF_CONTROL, 8'h20);
        wr(PBCS_OFF_CONTROL, 8'h30);
        rd(PBCS_OFF_CONTROL);
        period(180.0);
        chk("pll_en", pll_enable_out, 1'b0);
        wr(PBCS_OFF_BANDWIDTH, 8'h80);
        wr(PBCS_OFF_IRQ_MASK, 8'h01);
        wr(PBCS_OFF_CONTROL, 8'ha0);
        toggle_lock();
        chk_irq();
        rd(PBCS_OFF_BANDWIDTH);
        rd(PBCS_OFF_CONTROL);
        rd(PBCS_OFF_IRQ_STAT);
        chk_irq();
        wr(PBCS_OFF_IRQ_MASK, 8'h00);
        toggle_lock();
        chk_irq();
        wr(PBCS_OFF_CONTROL, 8'h20);
        chk_irq();
        rd(PBCS_OFF_CONTROL);
        @(posedge pclk);
        osc_cmd <= 1'b0;
        repeat (6) @(posedge pclk);
        chk("pll_en", pll_enable_out, 1'b0);
        stop_test();
    end
endmodule
